// File: pkg/sysref_pkg.sv
package sysref_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_CTRL1 = 10'h120;
  localparam logic [9:0] IDX_CTRL2 = 10'h121;
  localparam logic [9:0] IDX_CTRL3 = 10'h122;
  localparam logic [9:0] IDX_TS_DELAY = 10'h123;
  localparam logic [9:0] IDX_SETUP_HOLD = 10'h128;
  localparam logic [9:0] IDX_DIV_PHASE = 10'h129;
  localparam logic [9:0] IDX_EVENT_COUNT = 10'h12a;
  localparam logic [9:0] IDX_SYNC_SELECT = 10'h1ff;
  localparam logic [9:0] IDX_INT_STATUS = 10'h130;
  localparam logic [9:0] IDX_INT_ENABLE = 10'h131;
  localparam logic [9:0] IDX_INT_CLEAR = 10'h132;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int CNT_RST_BIT = 6;
  localparam int TRANS_SEL_BIT = 4;
  localparam int CLK_EDGE_BIT = 3;
  localparam int MODE_LSB = 1;
  localparam logic [6:0] CTRL1_MASK = 7'h5e;
  localparam logic [6:0] TS_DELAY_RST = 7'h40;
  localparam logic [3:0] PHASE_IN = 4'h0;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  typedef enum logic [1:0] {
    SR_DISABLED = 2'h0,
    SR_CONTINUOUS = 2'h1,
    SR_NSHOT = 2'h2
  } sr_mode_type;

  // Interrupt event bits
  localparam int EV_CAPTURE = 0;
  localparam int EV_LINK_DOWN = 1;
  localparam int EV_EARLY = 2;
  localparam int NUM_EV = 3;

endpackage

// File: design/sysref_capture_sync.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Late SYSREF edges within the positive window count as aligned.
// - Timestamp tag delayed by a 7-bit sample-clock count, reset 0x40.
// - Divider phase at capture recorded as 4-bit count of pclk cycles.
// - Eight-bit event counter increments on every captured SYSREF.
// - Event counter wraps from 255 to zero.
// - Counter reset bit clears the event counter.
// - Standard mode: captured SYSREF resets every internal divider.
// - Standard mode: a required divider phase change takes link down.
// - Timestamp mode: dividers are left untouched by SYSREF.
// - Timestamp mode: link_down output and its interrupt ignore SYSREF.
// - Timestamp mode: captured sample is tagged as output control bit.
// - Early SYSREF edges within the negative window are ignored.
// - N-shot mode skips a programmed number of initial transitions.
module sysref_capture_sync
  import sysref_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysref_pin,
  output logic divider_reset,
  output logic link_down,
  output logic sample_tag,
  output logic [3:0] divider_phase,
  output logic irq
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [6:0] ctrl1_ff;
  logic [3:0] ctrl2_ff;
  logic [3:0] ctrl3_ff;
  logic [6:0] ts_delay_ff;
  logic sync_mode_ff;
  logic [NUM_EV-1:0] int_status_ff;
  logic [NUM_EV-1:0] int_enable_ff;
  logic [3:0] setup_ff;
  logic [3:0] hold_ff;
  logic [3:0] phase_ff;
  logic [7:0] count_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  logic access;
  logic wr_en;
  logic [9:0] idx;
  logic [31:0] rd_val;
  logic rd_hit;

  function automatic logic wr_at(input logic [9:0] i);
    return wr_en && (idx == i);
  endfunction

  assign access = psel && penable && !pready_ff;
  assign wr_en = access && pwrite;
  assign idx = paddr[ADDR_W-1:2];

  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (idx)
      IDX_CTRL1: rd_val = {25'h0, ctrl1_ff};
      IDX_CTRL2: rd_val = {28'h0, ctrl2_ff};
      IDX_CTRL3: rd_val = {28'h0, ctrl3_ff};
      IDX_TS_DELAY: rd_val = {25'h0, ts_delay_ff};
      IDX_SETUP_HOLD: rd_val = {24'h0, hold_ff, setup_ff};
      IDX_DIV_PHASE: rd_val = {28'h0, phase_ff};
      IDX_EVENT_COUNT: rd_val = {24'h0, count_ff};
      IDX_SYNC_SELECT: rd_val = {31'h0, sync_mode_ff};
      IDX_INT_STATUS: rd_val = {29'h0, int_status_ff};
      IDX_INT_ENABLE: rd_val = {29'h0, int_enable_ff};
      IDX_INT_CLEAR: rd_val = 32'h0;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !rd_hit;
      if (access && !pwrite) begin
        prdata_ff <= rd_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_ff <= 7'h0;
      ctrl2_ff <= 4'h0;
      ctrl3_ff <= 4'h0;
      ts_delay_ff <= TS_DELAY_RST;
      sync_mode_ff <= 1'b0;
      int_enable_ff <= '0;
    end else begin
      if (wr_at(IDX_CTRL1)) begin
        ctrl1_ff <= pwdata[6:0] & CTRL1_MASK;
      end
      if (wr_at(IDX_CTRL2)) begin
        ctrl2_ff <= pwdata[3:0];
      end
      if (wr_at(IDX_CTRL3)) begin
        ctrl3_ff <= pwdata[3:0];
      end
      if (wr_at(IDX_TS_DELAY)) begin
        ts_delay_ff <= pwdata[6:0];
      end
      if (wr_at(IDX_SYNC_SELECT)) begin
        sync_mode_ff <= pwdata[0];
      end
      if (wr_at(IDX_INT_ENABLE)) begin
        int_enable_ff <= pwdata[NUM_EV-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // SYSREF synchroniser and transition detect
  // ------------------------------------------------------------------
  logic sr_meta_ff;
  logic sr_sync_ff;
  logic sr_prev_ff;
  logic sr_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_meta_ff <= 1'b0;
      sr_sync_ff <= 1'b0;
      sr_prev_ff <= 1'b0;
    end else begin
      sr_meta_ff <= sysref_pin;
      sr_sync_ff <= sr_meta_ff;
      sr_prev_ff <= sr_sync_ff;
    end
  end

  assign sr_edge = ctrl1_ff[TRANS_SEL_BIT] ? (sr_prev_ff && !sr_sync_ff)
                                           : (!sr_prev_ff && sr_sync_ff);

  // ------------------------------------------------------------------
  // Divider, windows and capture qualification
  // ------------------------------------------------------------------
  logic [3:0] div_cnt_ff;
  logic [3:0] lead;
  logic early;
  logic in_window;
  logic [3:0] skip_ff;
  logic shot_done_ff;
  logic nshot_hold;
  logic capture;
  sr_mode_type mode;

  assign mode = sr_mode_type'(ctrl1_ff[MODE_LSB+1:MODE_LSB]);
  assign lead = PHASE_IN - div_cnt_ff;
  assign early = (div_cnt_ff != PHASE_IN) && (ctrl3_ff[3:2] != 2'h0) &&
                 (lead <= {2'h0, ctrl3_ff[3:2]});
  assign in_window = div_cnt_ff <= {2'h0, ctrl3_ff[1:0]};
  assign nshot_hold = (mode == SR_NSHOT) &&
                      ((skip_ff != 4'h0) || shot_done_ff);
  assign capture = sr_edge && !early && !nshot_hold &&
                   ((mode == SR_CONTINUOUS) || (mode == SR_NSHOT));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_ff <= 4'h0;
      shot_done_ff <= 1'b0;
    end else if (wr_at(IDX_CTRL1)) begin
      skip_ff <= ctrl2_ff;
      shot_done_ff <= 1'b0;
    end else if (mode == SR_NSHOT && sr_edge && !early) begin
      if (skip_ff != 4'h0) begin
        skip_ff <= skip_ff - 4'h1;
      end else begin
        shot_done_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= PHASE_IN;
    end else if (capture && !sync_mode_ff) begin
      div_cnt_ff <= PHASE_IN;
    end else begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // Capture status and event counter
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= PHASE_IN;
      setup_ff <= 4'h0;
      hold_ff <= 4'h0;
    end else if (capture) begin
      phase_ff <= div_cnt_ff;
      setup_ff <= lead;
      hold_ff <= div_cnt_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 8'h0;
    end else if (ctrl1_ff[CNT_RST_BIT]) begin
      count_ff <= 8'h0;
    end else if (capture) begin
      count_ff <= count_ff + 8'h1;
    end
  end

  // ------------------------------------------------------------------
  // Link, divider and timestamp outputs
  // ------------------------------------------------------------------
  logic divider_reset_ff;
  logic link_down_ff;
  logic tag_ff;
  logic tag_pend_ff;
  logic [6:0] tag_cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_reset_ff <= 1'b0;
      link_down_ff <= 1'b0;
    end else begin
      divider_reset_ff <= capture && !sync_mode_ff;
      link_down_ff <= capture && !sync_mode_ff && !in_window;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_pend_ff <= 1'b0;
      tag_cnt_ff <= 7'h0;
      tag_ff <= 1'b0;
    end else begin
      tag_ff <= tag_pend_ff && (tag_cnt_ff == 7'h0);
      if (capture && sync_mode_ff) begin
        tag_pend_ff <= 1'b1;
        tag_cnt_ff <= ts_delay_ff;
      end else if (tag_pend_ff) begin
        if (tag_cnt_ff == 7'h0) begin
          tag_pend_ff <= 1'b0;
        end else begin
          tag_cnt_ff <= tag_cnt_ff - 7'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [NUM_EV-1:0] ev;

  always_comb begin
    ev = '0;
    ev[EV_CAPTURE] = capture;
    ev[EV_LINK_DOWN] = capture && !sync_mode_ff && !in_window;
    ev[EV_EARLY] = sr_edge && early;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      if (wr_at(IDX_INT_CLEAR)) begin
        int_status_ff <= (int_status_ff & ~pwdata[NUM_EV-1:0]) | ev;
      end else begin
        int_status_ff <= int_status_ff | ev;
      end
      irq_ff <= |(int_status_ff & int_enable_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign divider_reset = divider_reset_ff;
  assign link_down = link_down_ff;
  assign sample_tag = tag_ff;
  assign divider_phase = phase_ff;
  assign irq = irq_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ts_capture_s;
    capture && sync_mode_ff && !ctrl1_ff[CNT_RST_BIT];
  endsequence

  sequence std_capture_s;
    capture && !sync_mode_ff;
  endsequence

  apb_answer_a: assert property (
    psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one cycle");
  count_step_a: assert property (
    capture && !ctrl1_ff[CNT_RST_BIT] && count_ff != COUNT_MAX
    |=> count_ff == $past(count_ff) + 8'h1)
    else $error("count did not step");
  count_wrap_a: assert property (
    capture && !ctrl1_ff[CNT_RST_BIT] && count_ff == COUNT_MAX
    |=> count_ff == 8'h0)
    else $error("count did not wrap");
  count_clear_a: assert property (
    ctrl1_ff[CNT_RST_BIT] |=> count_ff == 8'h0)
    else $error("count not cleared");
  phase_record_a: assert property (
    capture |=> phase_ff == $past(div_cnt_ff))
    else $error("phase not recorded");
  div_reset_a: assert property (
    std_capture_s |=> div_cnt_ff == PHASE_IN && divider_reset_ff)
    else $error("divider not reset");
  div_keep_a: assert property (
    ts_capture_s |=> div_cnt_ff == $past(div_cnt_ff) + 4'h1
    && !divider_reset_ff && !link_down_ff)
    else $error("divider touched in timestamp mode");
  link_down_a: assert property (
    std_capture_s ##0 !in_window |=> link_down_ff)
    else $error("link not taken down");
  window_ok_a: assert property (
    std_capture_s ##0 in_window |=> !link_down_ff)
    else $error("late edge in window dropped link");
  early_ignore_a: assert property (
    sr_edge && early && !ctrl1_ff[CNT_RST_BIT]
    |=> count_ff == $past(count_ff))
    else $error("early edge counted");
  tag_zero_a: assert property (
    ts_capture_s ##0 ts_delay_ff == 7'h0 |-> ##2 tag_ff)
    else $error("tag missing");
  nshot_skip_a: assert property (
    mode == SR_NSHOT && sr_edge && !early && skip_ff != 4'h0 && !wr_en
    |-> !capture ##1 skip_ff == $past(skip_ff) - 4'h1)
    else $error("nshot skip wrong");

endmodule // sysref_capture_sync

// File: verif/sysref_gen.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// SYSREF source model
// ------------------------------------------------------------------
module sysref_gen (
  output logic sysref_pin,
  input wire logic pclk
);
  initial sysref_pin = 1'b0;

  // One rising edge, high for hi cycles, then quiet for gap cycles
  task automatic pulse(input int hi, input int gap);
    @(posedge pclk);
    sysref_pin <= 1'b1;
    repeat (hi) @(posedge pclk);
    sysref_pin <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
endmodule // sysref_gen

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sysref_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sysref_pin;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, divider_reset, link_down, sample_tag, irq, er;
  logic [3:0] divider_phase;
  int failures, num_checks, seed, n_rst, n_down;
  int l0, l1, a, b, d;
  int m_div, m_skip, m_done, m_cnt, m_ph, m_rst, m_down, m_st, m_sync;
  bit [31:0] m_c1, m_c2, m_c3;
  bit [2:0] m_q;
  bit m_edge, m_early, m_cap;

  sysref_capture_sync dut (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sysref_pin(sysref_pin),
    .divider_reset(divider_reset),
    .link_down(link_down),
    .sample_tag(sample_tag),
    .divider_phase(divider_phase),
    .irq(irq)
  );

  sysref_gen gen (
    .sysref_pin(sysref_pin),
    .pclk(pclk)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Reference model: edge detect, divider, counters, status
  // ------------------------------------------------------------------
  always @(posedge pclk) begin
    n_rst = n_rst + (divider_reset === 1'b1);
    n_down = n_down + (link_down === 1'b1);
    m_edge = m_c1[4] ? (m_q[2] && !m_q[1]) : (m_q[1] && !m_q[2]);
    m_early = m_div != 0 && m_c3[3:2] != 0 && 16 - m_div <= m_c3[3:2];
    m_cap = m_edge && !m_early && (m_c1[2:1] == 1 ||
            (m_c1[2:1] == 2 && m_skip == 0 && m_done == 0));
    if (m_c1[2:1] == 2 && m_edge && !m_early) begin
      if (m_skip != 0) begin
        m_skip--;
      end else begin
        m_done = 1;
      end
    end
    if (m_edge && m_early) begin
      m_st = m_st | 4;
    end
    if (m_cap) begin
      m_ph = m_div;
      m_st = m_st | 1;
    end
    if (m_cap && m_sync == 0) begin
      m_rst++;
      if (m_div > m_c3[1:0]) begin
        m_down++;
        m_st = m_st | 2;
      end
    end
    if (m_c1[6]) begin
      m_cnt = 0;
    end else if (m_cap) begin
      m_cnt = (m_cnt + 1) % 256;
    end
    m_div = (m_cap && m_sync == 0) ? 0 : (m_div + 1) % 16;
    m_q = {m_q[1:0], sysref_pin};
    if (presetn !== 1'b1) begin
      m_div = 0;
      m_q = '0;
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    if (idx == IDX_CTRL1) begin
      m_c1 = wd & CTRL1_MASK;
      m_skip = m_c2;
      m_done = 0;
    end
    if (idx == IDX_CTRL2) begin
      m_c2 = wd & 32'hf;
    end
    if (idx == IDX_CTRL3) begin
      m_c3 = wd & 32'hf;
    end
    if (idx == IDX_SYNC_SELECT) begin
      m_sync = wd & 32'h1;
    end
    if (idx == IDX_INT_CLEAR) begin
      m_st = m_st & ~wd;
    end
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rv, exp);
  endtask

  task automatic ts_lat(output int l);
    l = 0;
    fork
      gen.pulse(2, 4);
      while (sample_tag !== 1'b1 && l < 300) begin
        @(posedge pclk);
        l++;
      end
    join
  endtask

  initial begin
    #1000000;
    failures++;
    final_report();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = 87;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_TS_DELAY, 32'h40);
    rd(IDX_EVENT_COUNT, 32'h0);
    rd(IDX_DIV_PHASE, 32'h0);
    rd(IDX_SETUP_HOLD, 32'h0);
    rd(IDX_SYNC_SELECT, 32'h0);
    wr(10'h3f0, 32'h5a);
    rd(10'h3f0, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(IDX_EVENT_COUNT, 32'h5a);
    rd(IDX_EVENT_COUNT, 32'h0);
    d = $random(seed) & 32'h7f;
    wr(IDX_TS_DELAY, d | 32'h80);
    rd(IDX_TS_DELAY, d);
    $display("test registers done");

    wr(IDX_INT_ENABLE, 32'h1);
    wr(IDX_CTRL1, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_CTRL3, i % 4);
      gen.pulse(2, 6 + ($random(seed) & 15));
      rd(IDX_DIV_PHASE, m_ph);
      chk(n_rst, m_rst);
      chk(n_down, m_down);
      chk(divider_phase, m_ph);
      rd(IDX_SETUP_HOLD, (m_ph << 4) | ((16 - m_ph) % 16));
    end
    chk(irq, 1'b1);
    wr(IDX_INT_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    wr(IDX_INT_ENABLE, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(IDX_INT_CLEAR, 32'h7);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd(IDX_INT_CLEAR, 32'h0);
    wr(IDX_CTRL3, 32'he);
    for (int g = 0; g < 16; g++) begin
      gen.pulse(2, 6 + g);
    end
    chk(n_rst, m_rst);
    chk(n_down, m_down);
    rd(IDX_INT_STATUS, m_st);
    wr(IDX_CTRL3, 32'h0);
    $display("test standard mode done");

    wr(IDX_CTRL1, 32'h0);
    rd(IDX_EVENT_COUNT, m_cnt);
    wr(IDX_CTRL1, 32'h40);
    wr(IDX_CTRL1, 32'h0);
    rd(IDX_EVENT_COUNT, 32'h0);
    wr(IDX_CTRL1, 32'h2);
    repeat (255) gen.pulse(2, 4);
    wr(IDX_CTRL1, 32'h0);
    rd(IDX_EVENT_COUNT, 32'hff);
    wr(IDX_CTRL1, 32'h2);
    gen.pulse(2, 6);
    wr(IDX_CTRL1, 32'h0);
    gen.pulse(2, 6);
    rd(IDX_EVENT_COUNT, 32'h0);
    $display("test counter done");

    wr(IDX_CTRL1, 32'h12);
    repeat (2) gen.pulse(2, 6 + ($random(seed) & 15));
    chk(n_rst, m_rst);
    wr(IDX_CTRL2, 32'h2);
    wr(IDX_CTRL1, 32'h4);
    repeat (4) gen.pulse(2, 6);
    wr(IDX_CTRL1, 32'h0);
    rd(IDX_EVENT_COUNT, m_cnt);
    rd(IDX_DIV_PHASE, m_ph);
    $display("test edge select and n-shot done");

    wr(IDX_SYNC_SELECT, 32'h1);
    wr(IDX_CTRL1, 32'h2);
    l0 = n_rst;
    l1 = n_down;
    wr(IDX_TS_DELAY, 32'h0);
    ts_lat(a);
    d = 1 + ($random(seed) & 31);
    wr(IDX_TS_DELAY, d);
    ts_lat(b);
    chk(b - a, d);
    chk(n_rst - l0, 0);
    chk(n_down - l1, 0);
    $display("test timestamp done");
    final_report();
  end
endmodule // tb_top
